/* hw/uoy_out_desc.sv */
// Contract
// - Start address is field with three zero LSBs.
// - Each Y-buffer transaction starts at programmed address.
// - Hardware never modifies the start address field.
// - Count field holds bytes directly, up to 64.
// - Busy flag set means NAK host OUT.
// - One size field caps both buffers; bit7 zero.
//
// Top of the OUT endpoint Y-buffer descriptor block for endpoints 1 to 3.
// Assumes a packet engine on the same clock that frames each OUT data packet.
module uoy_out_desc
(
   input wire logic clk,
   input wire logic rst_n,
   input wire logic [4:0] reg_addr,
   input wire logic [7:0] reg_wdata,
   input wire logic reg_wr,
   input wire logic reg_rd,
   output logic [7:0] reg_rdata,
   input wire logic pkt_start,
   input wire logic [1:0] pkt_ep,
   input wire logic pkt_byte_valid,
   input wire logic [7:0] pkt_byte,
   input wire logic pkt_end,
   input wire logic pkt_abort,
   output logic hs_ack,
   output logic hs_nak,
   output logic ram_wr_en,
   output uoy_pkg::uoy_ram_wr_t ram_wr,
   output logic [2:0] ep_full
);

   // ---------------------------------------------------------------
   // Address decode
   // ---------------------------------------------------------------
   function automatic logic [2:0] uoy_ep_hit(input logic [4:0] addr, input logic [2:0] ofs);
      logic [2:0] hit;
      hit = 3'h0;
      for (int i = 0; i < uoy_pkg::EP_COUNT; i++)
      begin
         hit[i] = (addr[4:uoy_pkg::EP_FIELD_LSB] == 2'(i + 1)) && (addr[2:0] == ofs);
      end
      return hit;
   endfunction : uoy_ep_hit

   logic [2:0] hit_start;
   logic [2:0] hit_count;
   logic [2:0] hit_size;
   logic [2:0] commit_ep;
   logic [6:0] commit_count;
   logic [2:0] wr_start_ep;
   logic [2:0] wr_count_ep;
   logic [2:0] wr_size_ep;
   uoy_pkg::uoy_ep_cfg_t cfg [uoy_pkg::EP_COUNT];

   always_comb
   begin
      hit_start = uoy_ep_hit(reg_addr, uoy_pkg::OFS_Y_START);
      hit_count = uoy_ep_hit(reg_addr, uoy_pkg::OFS_Y_COUNT);
      hit_size = uoy_ep_hit(reg_addr, uoy_pkg::OFS_CAPACITY);
   end

   // ---------------------------------------------------------------
   // Write strobes per endpoint
   // ---------------------------------------------------------------
   always_comb
   begin
      wr_start_ep = reg_wr ? hit_start : 3'h0;
      wr_count_ep = reg_wr ? hit_count : 3'h0;
      wr_size_ep = reg_wr ? hit_size : 3'h0;
   end

   // ---------------------------------------------------------------
   // Per-endpoint descriptor registers
   // ---------------------------------------------------------------
   // The start field has no hardware write path at all, so a finished
   // transaction cannot disturb it.
   generate
      for (genvar g = 0; g < uoy_pkg::EP_COUNT; g++)
      begin : g_ep
         uoy_ep_regs u_regs
         (
            .clk(clk),
            .rst_n(rst_n),
            .wr_start(wr_start_ep[g]),
            .wr_count(wr_count_ep[g]),
            .wr_size(wr_size_ep[g]),
            .wdata(reg_wdata),
            .commit(commit_ep[g]),
            .commit_count(commit_count),
            .cfg(cfg[g])
         );
      end
   endgenerate

   // One process drives every busy bit, so the output has a single driver.
   always_comb
   begin
      for (int i = 0; i < uoy_pkg::EP_COUNT; i++)
      begin
         ep_full[i] = cfg[i].nak;
      end
   end

   // ---------------------------------------------------------------
   // Register read-back
   // ---------------------------------------------------------------
   // Reserved bits and unmapped offsets read back as zero.
   function automatic logic [7:0] uoy_read_value(input uoy_pkg::uoy_ep_cfg_t c,
      input logic [2:0] ofs);
      logic [7:0] value;
      value = 8'h00;
      case (ofs)
         uoy_pkg::OFS_Y_START:
         begin
            value = c.start;
         end
         uoy_pkg::OFS_Y_COUNT:
         begin
            value = {c.nak, c.count};
         end
         uoy_pkg::OFS_CAPACITY:
         begin
            value = {1'b0, c.size};
         end
         default:
         begin
            value = 8'h00;
         end
      endcase
      return value;
   endfunction : uoy_read_value

   logic [7:0] next_rdata;

   always_comb
   begin
      next_rdata = 8'h00;
      if (reg_rd)
      begin
         for (int i = 0; i < uoy_pkg::EP_COUNT; i++)
         begin
            if (hit_start[i] || hit_count[i] || hit_size[i])
            begin
               next_rdata = uoy_read_value(cfg[i], reg_addr[2:0]);
            end
         end
      end
   end

   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         reg_rdata <= 8'h00;
      end
      else
      begin
         reg_rdata <= next_rdata;
      end
   end

   // ---------------------------------------------------------------
   // Packet reception
   // ---------------------------------------------------------------
   uoy_pkg::uoy_state_t state;
   uoy_pkg::uoy_state_t next_state;
   logic [1:0] cur_ep;
   logic [1:0] next_cur_ep;
   logic [6:0] ofs;
   logic [6:0] next_ofs;
   logic ovf;
   logic next_ovf;
   logic next_hs_ack;
   logic next_hs_nak;
   logic ram_req;
   uoy_pkg::uoy_ram_wr_t ram_req_wr;
   logic [1:0] start_idx;
   uoy_pkg::uoy_ep_cfg_t cur_cfg;
   logic [3:0] busy_map;

   always_comb
   begin
      start_idx = 2'(pkt_ep - 2'h1);
      cur_cfg = cfg[cur_ep];
      // Endpoint 0 has no buffer, so it always looks busy and is refused.
      busy_map = {ep_full, 1'b1};
   end

   always_comb
   begin
      next_state = state;
      next_cur_ep = cur_ep;
      next_ofs = ofs;
      next_ovf = ovf;
      next_hs_ack = 1'b0;
      next_hs_nak = 1'b0;
      commit_ep = 3'h0;
      commit_count = ofs;
      ram_req = 1'b0;
      ram_req_wr = '{addr: uoy_pkg::uoy_buf_addr(cur_cfg.start, ofs), data: pkt_byte};
      unique case (state)
         uoy_pkg::UOY_IDLE:
         begin
            if (pkt_start)
            begin
               if (busy_map[pkt_ep])
               begin
                  // A full buffer refuses the whole packet.
                  next_hs_nak = 1'b1;
                  next_state = uoy_pkg::UOY_DRAIN;
               end
               else
               begin
                  next_cur_ep = start_idx;
                  next_ofs = 7'h00;
                  next_ovf = 1'b0;
                  next_state = uoy_pkg::UOY_RECV;
               end
            end
         end
         uoy_pkg::UOY_RECV:
         begin
            if (pkt_abort)
            begin
               next_state = uoy_pkg::UOY_IDLE;
            end
            else if (pkt_end)
            begin
               // Software may have set the flag by hand mid-packet; honour it.
               if (!ovf && !cur_cfg.nak)
               begin
                  commit_ep[cur_ep] = 1'b1;
                  next_hs_ack = 1'b1;
               end
               else
               begin
                  next_hs_nak = 1'b1;
               end
               next_state = uoy_pkg::UOY_IDLE;
            end
            else if (pkt_byte_valid)
            begin
               if (ofs < uoy_pkg::uoy_capacity(cur_cfg.size))
               begin
                  ram_req = 1'b1;
                  next_ofs = 7'(ofs + 7'h01);
               end
               else
               begin
                  next_ovf = 1'b1;
               end
            end
         end
         uoy_pkg::UOY_DRAIN:
         begin
            if (pkt_end || pkt_abort)
            begin
               next_state = uoy_pkg::UOY_IDLE;
            end
         end
         default:
         begin
            next_state = uoy_pkg::UOY_IDLE;
         end
      endcase
   end

   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         state <= uoy_pkg::UOY_IDLE;
         cur_ep <= 2'h0;
         ofs <= 7'h00;
         ovf <= 1'b0;
         hs_ack <= 1'b0;
         hs_nak <= 1'b0;
      end
      else
      begin
         state <= next_state;
         cur_ep <= next_cur_ep;
         ofs <= next_ofs;
         ovf <= next_ovf;
         hs_ack <= next_hs_ack;
         hs_nak <= next_hs_nak;
      end
   end

   // ---------------------------------------------------------------
   // Shared RAM write stage
   // ---------------------------------------------------------------
   uoy_ram_port u_ram_port
   (
      .clk(clk),
      .rst_n(rst_n),
      .req(ram_req),
      .req_wr(ram_req_wr),
      .wr_en(ram_wr_en),
      .wr(ram_wr)
   );

endmodule : uoy_out_desc

/* shared/uoy_pkg.sv */
// Constants, carrier types and helpers for the OUT endpoint Y-buffer descriptor block.
// Assumes one 125 MHz clock domain shared by the register port and the packet engine.
package uoy_pkg;

   // ---------------------------------------------------------------
   // Register map
   // ---------------------------------------------------------------
   localparam int REG_ADDR_W = 5;
   localparam int EP_COUNT = 3;
   localparam logic [2:0] OFS_Y_START = 3'h5;
   localparam logic [2:0] OFS_Y_COUNT = 3'h6;
   localparam logic [2:0] OFS_CAPACITY = 3'h7;
   localparam int EP_FIELD_LSB = 3;
   localparam int NAK_BIT = 7;
   localparam logic [7:0] RST_START = 8'h00;
   localparam logic [6:0] RST_COUNT = 7'h00;
   localparam logic RST_NAK = 1'b0;
   localparam logic [6:0] RST_SIZE = 7'h00;

   // ---------------------------------------------------------------
   // Shared buffer geometry
   // ---------------------------------------------------------------
   localparam int BUF_ADDR_W = 11;
   localparam int ADDR_PAD_W = 3;
   localparam logic [6:0] MAX_BYTES = 7'h40;

   typedef struct packed
   {
      logic [7:0] start;
      logic nak;
      logic [6:0] count;
      logic [6:0] size;
   } uoy_ep_cfg_t;

   typedef struct packed
   {
      logic [10:0] addr;
      logic [7:0] data;
   } uoy_ram_wr_t;

   typedef enum logic [1:0]
   {
      UOY_IDLE = 2'b00,
      UOY_RECV = 2'b01,
      UOY_DRAIN = 2'b11
   } uoy_state_t;

   // Start field is address bits 10..3; the low three bits are always zero.
   function automatic logic [10:0] uoy_buf_addr(input logic [7:0] start, input logic [6:0] ofs);
      logic [10:0] base;
      base = {start, 3'h0};
      return 11'(base + {4'h0, ofs});
   endfunction : uoy_buf_addr

   // Codes above 64 are illegal; clamping keeps a bad setting from running past 64 bytes.
   function automatic logic [6:0] uoy_capacity(input logic [6:0] size);
      return (size > MAX_BYTES) ? MAX_BYTES : size;
   endfunction : uoy_capacity

endpackage : uoy_pkg

/* hw/uoy_ep_regs.sv */
// One endpoint's Y-buffer start, Y byte count with busy flag, and shared buffer size.
// Assumes write strobes are one cycle and already decoded for this endpoint.
module uoy_ep_regs
(
   input wire logic clk,
   input wire logic rst_n,
   input wire logic wr_start,
   input wire logic wr_count,
   input wire logic wr_size,
   input wire logic [7:0] wdata,
   input wire logic commit,
   input wire logic [6:0] commit_count,
   output uoy_pkg::uoy_ep_cfg_t cfg
);

   uoy_pkg::uoy_ep_cfg_t next_cfg;

   // ---------------------------------------------------------------
   // Next values
   // ---------------------------------------------------------------
   always_comb
   begin
      next_cfg = cfg;
      if (wr_start)
      begin
         next_cfg.start = wdata;
      end
      if (wr_size)
      begin
         next_cfg.size = wdata[6:0];
      end
      // The packet engine's update wins over a software write in the same cycle.
      if (commit)
      begin
         next_cfg.count = commit_count;
         next_cfg.nak = 1'b1;
      end
      else if (wr_count)
      begin
         next_cfg.count = wdata[6:0];
         next_cfg.nak = wdata[uoy_pkg::NAK_BIT];
      end
   end

   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         cfg <= '{start: uoy_pkg::RST_START, nak: uoy_pkg::RST_NAK,
                  count: uoy_pkg::RST_COUNT, size: uoy_pkg::RST_SIZE};
      end
      else
      begin
         cfg <= next_cfg;
      end
   end

endmodule : uoy_ep_regs

/* hw/uoy_ram_port.sv */
// Output stage toward the shared buffer RAM: registers one byte write per request.
// Assumes the RAM takes a write on every cycle in which the enable is high.
module uoy_ram_port
(
   input wire logic clk,
   input wire logic rst_n,
   input wire logic req,
   input uoy_pkg::uoy_ram_wr_t req_wr,
   output logic wr_en,
   output uoy_pkg::uoy_ram_wr_t wr
);

   logic next_wr_en;
   uoy_pkg::uoy_ram_wr_t next_wr;

   always_comb
   begin
      next_wr_en = req;
      next_wr = req ? req_wr : wr;
   end

   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         wr_en <= 1'b0;
         wr <= '0;
      end
      else
      begin
         wr_en <= next_wr_en;
         wr <= next_wr;
      end
   end

endmodule : uoy_ram_port

/* bench/uoy_out_desc_props.sv */
// Checker for the OUT endpoint Y-buffer descriptor block.
// Sees only the top module ports and is bound at the foot of this file.
module uoy_out_desc_props
(
   input logic clk,
   input logic rst_n,
   input logic [4:0] reg_addr,
   input logic [7:0] reg_wdata,
   input logic reg_wr,
   input logic reg_rd,
   input logic [7:0] reg_rdata,
   input logic pkt_start,
   input logic [1:0] pkt_ep,
   input logic [7:0] pkt_byte,
   input logic hs_ack,
   input logic hs_nak,
   input logic ram_wr_en,
   input uoy_pkg::uoy_ram_wr_t ram_wr,
   input logic [2:0] ep_full
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [7:0] st [4];
   logic [1:0] ce;
   logic [6:0] wc;
   default clocking @(posedge clk);
   endclocking
   default disable iff (!rst_n);
   // Shadow start fields, so checks need no reach into the design.
   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         st <= '{default: 8'h00};
         ce <= 2'd0;
         wc <= 7'd0;
      end
      else
      begin
         if (reg_wr && reg_addr[2:0] == 3'h5)
            st[reg_addr[4:3]] <= reg_wdata;
         if (pkt_start)
            ce <= pkt_ep;
         wc <= pkt_start ? 7'd0 : wc + 7'(ram_wr_en);
      end
   end
   rsv_bit_a: assert property (reg_rd && reg_addr[2:0] == 3'h7 |=> !reg_rdata[7])
      else $error("reserved bit read high");
   start_kept_a: assert property (reg_rd && reg_addr[2:0] == 3'h5 && reg_addr[4:3] != 0
      |=> reg_rdata == st[$past(reg_addr[4:3])]) else $error("start changed");
   nak_write_a: assert property (reg_wr && reg_addr == 5'h0e
      |=> hs_ack || ep_full[0] == $past(reg_wdata[7])) else $error("flag not written");
   nak_refuse_a: assert property (pkt_start && pkt_ep != 0 && ep_full[pkt_ep - 2'd1]
      |=> hs_nak) else $error("busy buffer not refused");
   ack_sets_a: assert property (hs_ack |-> ep_full[ce - 2'd1])
      else $error("flag not set on accept");
   ram_addr_a: assert property (ram_wr_en |-> ram_wr.addr == 11'({st[ce], 3'h0} + wc))
      else $error("bad buffer address");
   ram_data_a: assert property (ram_wr_en |-> ram_wr.data == $past(pkt_byte))
      else $error("bad buffer data");
   ram_cap_a: assert property (ram_wr_en |-> wc < 7'd64)
      else $error("write past 64 bytes");
   cover property (hs_ack);
   cover property (hs_nak);
   cover property (ram_wr_en);
endmodule : uoy_out_desc_props

bind uoy_out_desc uoy_out_desc_props chk_u (.*);

/* bench/uoy_host_model.sv */
// Host model: frames OUT data packets toward the descriptor block.
// Assumes each send returns before the next one starts.
module uoy_host_model
(
   input logic clk,
   output logic pkt_start,
   output logic [1:0] pkt_ep,
   output logic pkt_byte_valid,
   output logic [7:0] pkt_byte,
   output logic pkt_end,
   output logic pkt_abort
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [7:0] sent [$];
   initial
   begin
      {pkt_start, pkt_ep, pkt_byte_valid, pkt_byte, pkt_end, pkt_abort} = 14'h0;
   end
   // Random idle cycles play a slow host; idle data is inverted, never left stale.
   task automatic send(input logic [1:0] ep, input int n, input bit ab, inout integer seed);
      logic [7:0] b;
      b = 8'h00;
      sent.delete();
      @(posedge clk);
      pkt_start <= 1'b1;
      pkt_ep <= ep;
      for (int k = 0; k < n; k++)
      begin
         b = 8'($random(seed));
         @(posedge clk);
         pkt_start <= 1'b0;
         pkt_byte_valid <= 1'b1;
         pkt_byte <= b;
         sent.push_back(b);
         if (seed[0])
         begin
            @(posedge clk);
            pkt_byte_valid <= 1'b0;
            pkt_byte <= ~b;
         end
      end
      @(posedge clk);
      {pkt_start, pkt_byte_valid} <= 2'b00;
      pkt_byte <= ~b;
      pkt_end <= !ab;
      pkt_abort <= ab;
      @(posedge clk);
      {pkt_end, pkt_abort} <= 2'b00;
   endtask : send
endmodule : uoy_host_model

/* bench/tb.sv */
// Self-checking bench for the OUT endpoint Y-buffer descriptor block.
// Assumes the host model drives the packet side and the checker is bound.
`define CHK(a, e) begin n_tests++; if ((a) !== (e)) begin num_errors++; \
   $display("Error %0t: got %h want %h", $time, a, e); end end
module tb;
   timeunit 1ns;
   timeprecision 1ps;
   logic clk = 1'b0, rst_n = 1'b0, reg_wr = 1'b0, reg_rd = 1'b0;
   logic [4:0] reg_addr = 5'h00;
   logic [7:0] reg_wdata = 8'h00, reg_rdata, pkt_byte, d, st;
   logic pkt_start, pkt_byte_valid, pkt_end, pkt_abort, hs_ack, hs_nak, ram_wr_en;
   logic [1:0] pkt_ep;
   logic [2:0] ep_full;
   logic [6:0] sz;
   uoy_pkg::uoy_ram_wr_t ram_wr;
   logic [7:0] mem [2048];
   integer seed = 32'haaf1_4456;
   int num_errors = 0, n_tests = 0, acks = 0, naks = 0, n;
   uoy_out_desc dut_u (.*);
   uoy_host_model host_u (.*);
   always #4 clk = ~clk;
   always @(posedge clk)
   begin
      if (ram_wr_en === 1'b1)
         mem[ram_wr.addr] = ram_wr.data;
      acks += int'(hs_ack === 1'b1);
      naks += int'(hs_nak === 1'b1);
   end
   function automatic logic [10:0] exp_addr(input logic [7:0] s, input int k);
      return 11'({s, 3'h0} + k);
   endfunction : exp_addr
   task automatic wr(input logic [4:0] a, input logic [7:0] v);
      @(posedge clk);
      reg_wr <= 1'b1;
      reg_addr <= a;
      reg_wdata <= v;
      @(posedge clk);
      reg_wr <= 1'b0;
   endtask : wr
   task automatic cr(input logic [4:0] a, input logic [7:0] e);
      @(posedge clk);
      reg_rd <= 1'b1;
      reg_addr <= a;
      @(posedge clk);
      reg_rd <= 1'b0;
      #1 d = reg_rdata;
      `CHK(d, e)
   endtask : cr
   task automatic pkt(input logic [1:0] ep, input int k, input bit ab, input int ea, input int en);
      int a0;
      int n0;
      a0 = acks;
      n0 = naks;
      host_u.send(ep, k, ab, seed);
      repeat (2) @(posedge clk);
      `CHK(acks - a0, ea)
      `CHK(naks - n0, en)
   endtask : pkt
   task automatic wrap_up();
      $display("tests %0d errors %0d", n_tests, num_errors);
      if (num_errors == 0 && n_tests > 0)
         $display("Result: passed");
      else
         $display("Result: failed");
      $finish;
   endtask : wrap_up
   initial
   begin
      #200000;
      num_errors++;
      wrap_up();
   end
   initial
   begin
      repeat (4) @(posedge clk);
      rst_n <= 1'b1;
      wr(5'h05, 8'hff);
      cr(5'h05, 8'h00);
      pkt(2'h0, 1, 1'b0, 0, 1);
      for (int ep = 1; ep < 4; ep++)
      begin
         st = 8'($random(seed));
         sz = (ep == 3) ? 7'h40 : 7'(1 + {$random(seed)} % 63);
         n = 1 + {$random(seed)} % sz;
         wr({2'(ep), 3'h5}, st);
         wr({2'(ep), 3'h7}, {1'b0, sz});
         wr({2'(ep), 3'h6}, 8'h00);
         cr({2'(ep), 3'h7}, {1'b0, sz});
         pkt(2'(ep), sz + 1, 1'b0, 0, 1);
         pkt(2'(ep), n, 1'b1, 0, 0);
         cr({2'(ep), 3'h6}, 8'h00);
         pkt(2'(ep), n, 1'b0, 1, 0);
         cr({2'(ep), 3'h6}, {1'b1, 7'(n)});
         `CHK(ep_full[ep - 1], 1'b1)
         for (int k = 0; k < n; k++)
            `CHK(mem[exp_addr(st, k)], host_u.sent[k])
         pkt(2'(ep), 1, 1'b0, 0, 1);
         cr({2'(ep), 3'h5}, st);
         wr({2'(ep), 3'h6}, 8'h05);
         cr({2'(ep), 3'h6}, 8'h05);
         `CHK(ep_full[ep - 1], 1'b0)
         $display("test ep %0d done", ep);
      end
      wrap_up();
   end
endmodule : tb
